//--- verilog/hpc_cfg.svh
// constants for the hibernation power controller
// assumes a single 10 MHz system clock and an active-low asynchronous reset
// ------------------------------------------------------------
// ------------------------------------------------------------
`ifndef HPC_CFG_SVH
`define HPC_CFG_SVH

`define HPC_CLK_PERIOD_NS 32'd100
`define HPC_POR_TIME_NS 32'd1000
`define HPC_POR_CYCLES (((`HPC_POR_TIME_NS) + (`HPC_CLK_PERIOD_NS) - 32'd1) / (`HPC_CLK_PERIOD_NS))
`define HPC_POR_CNT_W 8
`define HPC_XTAL_DIV_MAX 7'h7f
`define HPC_PREDIV_NOM 15'h7fff
`define HPC_MATCH_RST 32'hffff_ffff
`define HPC_TRIM_SEC 6'h3f
`define HPC_LOWBAT_LEVEL 8'h60
`define HPC_LEVEL_W 8

`endif

//--- verilog/hpc_pkg.sv
// types shared by the hibernation power controller files
// assumes hpc_cfg.svh holds the numeric constants
package hpc_pkg;

  typedef enum logic [1:0] {
    HPC_RUN = 2'b00,
    HPC_HIB = 2'b01,
    HPC_WAKE = 2'b10,
    HPC_POR = 2'b11
  } hpc_state_e;

  typedef enum logic [1:0] {
    HPC_SEL_LOAD = 2'b00,
    HPC_SEL_MATCH0 = 2'b01,
    HPC_SEL_MATCH1 = 2'b10,
    HPC_SEL_TRIM = 2'b11
  } hpc_sel_e;

  typedef struct packed {
    logic osc_enable;
    logic osc_type_select;
    logic rtc_enable;
    logic sleep_request;
    logic pin_wake_enable;
    logic match_wake_enable;
    logic low_batt_detect_enable;
    logic low_batt_abort;
  } hpc_ctrl_s;

  typedef struct packed {
    logic valid;
    hpc_sel_e sel;
    logic [31:0] data;
  } hpc_wr_s;

endpackage : hpc_pkg

//--- verilog/hpc_rtc.sv
// real-time counter with predivider, trim and two match values
// assumes ref_tick is a one-cycle pulse per 32.768 kHz period
`timescale 1ns/1ps
`include "hpc_cfg.svh"
module hpc_rtc (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ref_tick,
  input wire logic rtc_enable,
  input wire hpc_pkg::hpc_wr_s wr,
  output logic [31:0] count,
  output logic match_hit
);
  import hpc_pkg::*;

  logic [31:0] count_q;
  logic [31:0] m0_q;
  logic [31:0] m1_q;
  logic [14:0] trim_q;
  logic [14:0] pre_q;
  logic [5:0] sec_q;
  logic hit_q;

  wire sec_tick = rtc_enable && ref_tick && (pre_q == 15'h0000);
  // trim is used for one second in every 64
  wire [14:0] pre_reload = (sec_q == `HPC_TRIM_SEC) ? trim_q : `HPC_PREDIV_NOM;
  wire load_wr = wr.valid && (wr.sel == HPC_SEL_LOAD);

  // ------------------------------------------------------------
  // predivider and counter
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_q <= `HPC_PREDIV_NOM;
      sec_q <= 6'h00;
      count_q <= 32'h0000_0000;
    end else begin
      if (rtc_enable && ref_tick) begin
        pre_q <= sec_tick ? pre_reload : pre_q - 15'h0001;
      end
      if (sec_tick) begin
        sec_q <= sec_q + 6'h01;
      end
      if (load_wr) begin
        count_q <= wr.data;
      end else if (sec_tick) begin
        count_q <= count_q + 32'h0000_0001;
      end
    end
  end

  // ------------------------------------------------------------
  // match and trim values
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      m0_q <= `HPC_MATCH_RST;
      m1_q <= `HPC_MATCH_RST;
      trim_q <= `HPC_PREDIV_NOM;
      hit_q <= 1'b0;
    end else begin
      if (wr.valid && wr.sel == HPC_SEL_MATCH0) m0_q <= wr.data;
      if (wr.valid && wr.sel == HPC_SEL_MATCH1) m1_q <= wr.data;
      if (wr.valid && wr.sel == HPC_SEL_TRIM) trim_q <= wr.data[14:0];
      hit_q <= (count_q == m0_q) || (count_q == m1_q);
    end
  end

  // registered, so reads may follow each other with no gap
  assign count = count_q;
  assign match_hit = hit_q;

  property p_sec_step;
    @(posedge clk) disable iff (!nrst)
    (sec_tick && !load_wr) |=> (count_q == $past(count_q) + 32'h0000_0001);
  endproperty
  a_sec_step: assert property (p_sec_step) else $error("counter did not step on second tick");

  property p_match;
    @(posedge clk) disable iff (!nrst)
    (count_q == m0_q) |=> hit_q;
  endproperty
  a_match: assert property (p_match) else $error("match zero not flagged");

endmodule : hpc_rtc

//--- verilog/hpc_top.sv
// hibernation power controller: reference clock, write sync, power sequencing
// assumes all inputs synchronous to clk; control bits arrive as plain ports
`timescale 1ns/1ps
`include "hpc_cfg.svh"
module hpc_top (
  input wire logic clk,
  input wire logic nrst,
  input wire hpc_pkg::hpc_ctrl_s ctrl,
  input wire hpc_pkg::hpc_wr_s wr,
  output logic wr_busy,
  input wire logic wake_n,
  input wire logic vdd_good,
  input wire logic [`HPC_LEVEL_W-1:0] vdd_level,
  input wire logic [`HPC_LEVEL_W-1:0] vbat_level,
  input wire logic osc_in,
  output logic osc_out,
  output logic regulator_off_n_o,
  output logic regulator_off_n_oe,
  output logic supply_from_batt,
  output logic low_batt,
  output logic chip_por_n,
  output logic hibernating,
  output logic [31:0] rtc_counter_value
);
  import hpc_pkg::*;

  localparam logic [`HPC_POR_CNT_W-1:0] POR_LAST = `HPC_POR_CNT_W'(`HPC_POR_CYCLES - 32'd1);

  // ------------------------------------------------------------
  // reference clock
  // ------------------------------------------------------------
  logic osc_prev_q;
  logic [6:0] div_q;
  logic osc_out_q;

  wire osc_rise = osc_in && !osc_prev_q;
  wire xtal_mode = !ctrl.osc_type_select;
  wire div_wrap = (div_q == `HPC_XTAL_DIV_MAX);
  // no reference tick, so no counting, until the oscillator is enabled
  wire ref_tick = ctrl.osc_enable && osc_rise && (ctrl.osc_type_select || div_wrap);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_prev_q <= 1'b0;
      div_q <= 7'h00;
      osc_out_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_in;
      if (!ctrl.osc_enable || !xtal_mode) begin
        div_q <= 7'h00;
      end else if (osc_rise) begin
        div_q <= div_q + 7'h01;
      end
      // crystal feedback only in crystal mode; idle low otherwise
      osc_out_q <= ctrl.osc_enable && xtal_mode && !osc_in;
    end
  end

  // ------------------------------------------------------------
  // write hand-off to slow domain
  // ------------------------------------------------------------
  // a write waits for the next reference tick so it lands on the slow
  // clock; with the oscillator off it is applied on the next cycle
  hpc_wr_s pend_q;
  hpc_wr_s apply_wr;

  wire apply_now = pend_q.valid && (ref_tick || !ctrl.osc_enable);
  wire take_wr = wr.valid && !pend_q.valid;

  assign apply_wr = '{valid: apply_now, sel: pend_q.sel, data: pend_q.data};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= '0;
    end else if (take_wr) begin
      pend_q <= wr;
    end else if (apply_now) begin
      pend_q.valid <= 1'b0;
    end
  end

  assign wr_busy = pend_q.valid;

  logic rtc_match;

  hpc_rtc u_rtc (
    .clk(clk),
    .nrst(nrst),
    .ref_tick(ref_tick),
    .rtc_enable(ctrl.rtc_enable),
    .wr(apply_wr),
    .count(rtc_counter_value),
    .match_hit(rtc_match)
  );

  // ------------------------------------------------------------
  // supply selection and battery check
  // ------------------------------------------------------------
  logic supply_batt_q;
  logic low_q;
  hpc_state_e state_q;
  hpc_state_e state_d;

  wire batt_higher = vbat_level > vdd_level;
  wire batt_low_now = ctrl.low_batt_detect_enable && (vbat_level < `HPC_LOWBAT_LEVEL);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      supply_batt_q <= 1'b0;
      low_q <= 1'b0;
    end else begin
      supply_batt_q <= batt_higher;
      // battery is not measured while hibernating
      if (state_q != HPC_HIB) begin
        low_q <= batt_low_now;
      end
    end
  end

  assign supply_from_batt = supply_batt_q;
  assign low_batt = low_q;

  // ------------------------------------------------------------
  // power sequencer
  // ------------------------------------------------------------
  logic req_prev_q;
  logic [`HPC_POR_CNT_W-1:0] por_cnt_q;
  logic off_q;
  logic por_n_q;

  // edge, not level: the request bit may still read set after wake-up
  wire req_rise = ctrl.sleep_request && !req_prev_q;
  wire wake_any = ctrl.pin_wake_enable || ctrl.match_wake_enable;
  wire entry_block = ctrl.low_batt_abort && low_q;
  wire pin_wake = ctrl.pin_wake_enable && !wake_n;
  wire match_wake = ctrl.match_wake_enable && rtc_match;
  wire go_sleep = req_rise && wake_any && !entry_block;
  wire go_wake = pin_wake || match_wake;

  always_comb begin
    state_d = state_q;
    case (state_q)
      HPC_RUN: begin
        if (go_sleep) state_d = HPC_HIB;
      end
      HPC_HIB: begin
        if (go_wake) state_d = HPC_WAKE;
      end
      HPC_WAKE: begin
        if (vdd_good) state_d = HPC_POR;
      end
      HPC_POR: begin
        if (por_cnt_q == POR_LAST) state_d = HPC_RUN;
      end
      default: state_d = HPC_POR;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= HPC_POR;
      req_prev_q <= 1'b0;
      por_cnt_q <= '0;
      off_q <= 1'b0;
      por_n_q <= 1'b0;
    end else begin
      state_q <= state_d;
      req_prev_q <= ctrl.sleep_request;
      por_cnt_q <= (state_q == HPC_POR) ? por_cnt_q + 1'b1 : '0;
      off_q <= (state_d == HPC_HIB);
      por_n_q <= (state_d == HPC_RUN);
    end
  end

  // open drain: low while hibernating, released otherwise
  assign regulator_off_n_o = 1'b0;
  assign regulator_off_n_oe = off_q;
  assign hibernating = off_q;
  assign chip_por_n = por_n_q;
  assign osc_out = osc_out_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence s_por_held;
    (!chip_por_n) [*8] ##1 !chip_por_n ##1 !chip_por_n;
  endsequence

  sequence s_reg_released;
    !regulator_off_n_oe ##1 (state_q != HPC_HIB);
  endsequence

  property p_off_in_hib;
    @(posedge clk) disable iff (!nrst)
    (state_q == HPC_HIB) |-> (regulator_off_n_oe && !regulator_off_n_o);
  endproperty
  a_off_in_hib: assert property (p_off_in_hib) else $error("regulator not held off in hibernation");

  property p_enter;
    @(posedge clk) disable iff (!nrst)
    (state_q == HPC_RUN && go_sleep) |=> (state_q == HPC_HIB) && regulator_off_n_oe;
  endproperty
  a_enter: assert property (p_enter) else $error("sleep request did not enter hibernation");

  property p_block;
    @(posedge clk) disable iff (!nrst)
    (state_q == HPC_RUN && entry_block) |=> !regulator_off_n_oe;
  endproperty
  a_block: assert property (p_block) else $error("hibernation entered on low battery");

  property p_pin_wake;
    @(posedge clk) disable iff (!nrst)
    (state_q == HPC_HIB && ctrl.pin_wake_enable && !wake_n) |=> s_reg_released;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("wake pin did not release regulator");

  property p_match_wake;
    @(posedge clk) disable iff (!nrst)
    (state_q == HPC_HIB && ctrl.match_wake_enable && rtc_match) |=> (state_q == HPC_WAKE);
  endproperty
  a_match_wake: assert property (p_match_wake) else $error("counter match did not wake");

  property p_por;
    @(posedge clk) disable iff (!nrst)
    (state_q == HPC_WAKE && vdd_good) |=> s_por_held ##1 chip_por_n;
  endproperty
  a_por: assert property (p_por) else $error("power-on reset length wrong");

  property p_supply;
    @(posedge clk) disable iff (!nrst)
    (vbat_level > vdd_level) |=> supply_from_batt;
  endproperty
  a_supply: assert property (p_supply) else $error("higher battery supply not selected");

  property p_low_batt;
    @(posedge clk) disable iff (!nrst)
    (batt_low_now && state_q != HPC_HIB) |=> low_batt;
  endproperty
  a_low_batt: assert property (p_low_batt) else $error("low battery not flagged");

  property p_div;
    @(posedge clk) disable iff (!nrst)
    (ref_tick && xtal_mode) |-> (div_q == `HPC_XTAL_DIV_MAX) && osc_rise;
  endproperty
  a_div: assert property (p_div) else $error("crystal tick off the divide point");

  property p_pass;
    @(posedge clk) disable iff (!nrst)
    (ctrl.osc_enable && ctrl.osc_type_select && $rose(osc_in)) |-> ref_tick;
  endproperty
  a_pass: assert property (p_pass) else $error("oscillator edge not passed through");

  property p_clk_off;
    @(posedge clk) disable iff (!nrst)
    !ctrl.osc_enable |-> !ref_tick;
  endproperty
  a_clk_off: assert property (p_clk_off) else $error("reference ticks while disabled");

  property p_write;
    @(posedge clk) disable iff (!nrst)
    (wr_busy && !ctrl.osc_enable) |=> !wr_busy;
  endproperty
  a_write: assert property (p_write) else $error("pending write not applied");

endmodule : hpc_top

//--- test/hpc_partner.sv
// far side: external regulator, wake source and clock source
// assumes the power pin and wake pin both have pull-ups
`timescale 1ns/1ps
module hpc_partner #(
  parameter int RAMP = 4,
  parameter int XTAL_HALF_NS = 300,
  parameter int OSC_HALF_NS = 1500
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic regulator_off_n_o,
  input wire logic regulator_off_n_oe,
  input wire logic wake_req,
  input wire logic osc_slow,
  output logic wake_n,
  output logic vdd_good,
  output logic osc_in
);
  logic pin_level;
  int ramp_q;
  // pull-up wins unless the open drain pulls down
  assign pin_level = regulator_off_n_oe ? regulator_off_n_o : 1'b1;
  assign wake_n = wake_req ? 1'b0 : 1'b1;
  // regulator output takes a few cycles to come up, drops at once
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ramp_q <= RAMP;
      vdd_good <= 1'b1;
    end else if (!pin_level) begin
      ramp_q <= 0;
      vdd_good <= 1'b0;
    end else begin
      if (ramp_q < RAMP) ramp_q <= ramp_q + 1;
      vdd_good <= (ramp_q >= RAMP - 1);
    end
  end
  // clock source always runs; edges kept off the bench clock edges
  initial begin
    osc_in = 1'b0;
    #25;
    forever begin
      #(osc_slow ? OSC_HALF_NS : XTAL_HALF_NS);
      osc_in = ~osc_in;
    end
  end
endmodule : hpc_partner

//--- test/hpc_top_test.sv
// self-checking bench for the hibernation power controller
// assumes hpc_partner stands for regulator, wake pin and clock source
`timescale 1ns/1ps
`include "hpc_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin error_cnt++; $display("[ERR] %0t %h %h", $time, a, b); end end
module hpc_top_test;
  import hpc_pkg::*;
  // ----
  // signals and instances
  // ----
  logic clk, nrst, wake_n, vdd_good, osc_in, osc_out, wake_req, osc_slow, a;
  logic wr_busy, reg_o, reg_oe, from_batt, low_batt, por_n, regulator_off_n;
  logic [7:0] vdd_level, vbat_level;
  logic [31:0] cnt;
  hpc_ctrl_s ctrl;
  hpc_wr_s wr;
  int error_cnt, checked, seed, i, dur, exp_cnt;
  hpc_top hpc_top_i (.clk(clk), .nrst(nrst), .ctrl(ctrl), .wr(wr), .wr_busy(wr_busy), .wake_n(wake_n),
    .vdd_good(vdd_good), .vdd_level(vdd_level), .vbat_level(vbat_level), .osc_in(osc_in), .osc_out(osc_out),
    .regulator_off_n_o(reg_o), .regulator_off_n_oe(reg_oe), .supply_from_batt(from_batt),
    .low_batt(low_batt), .chip_por_n(por_n), .hibernating(regulator_off_n), .rtc_counter_value(cnt));
  hpc_partner hpc_partner_i (.clk(clk), .nrst(nrst), .regulator_off_n_o(reg_o), .regulator_off_n_oe(reg_oe),
    .wake_req(wake_req), .osc_slow(osc_slow), .wake_n(wake_n), .vdd_good(vdd_good), .osc_in(osc_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task summarize;
    if (error_cnt == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // one slow-domain write; dur ends as cycles spent waiting for wr_busy to clear
  task automatic wr_do(input hpc_sel_e s, input logic [31:0] d);
    wr.valid = 1'b1;
    wr.sel = s;
    wr.data = d;
    cyc(1);
    wr.valid = 1'b0;
    for (i = 0; i < 3 && wr_busy !== 1'b1; i++) cyc(1);
    `CHK(wr_busy, 1'b1)
    for (dur = 0; dur < 900 && wr_busy !== 1'b0; dur++) cyc(1);
    `CHK(wr_busy, 1'b0)
    cyc(1);
  endtask : wr_do
  // request is edge-triggered, so drop it first
  task automatic slp;
    ctrl.sleep_request = 1'b0;
    cyc(1);
    ctrl.sleep_request = 1'b1;
    cyc(2);
  endtask : slp
  initial begin
    #2000000;
    error_cnt++;
    summarize();
  end
  // ----
  // scenarios
  // ----
  initial begin
    error_cnt = 0;
    checked = 0;
    seed = 32'haac7;
    nrst = 1'b0;
    ctrl = '0;
    wr = '0;
    wake_req = 1'b0;
    osc_slow = 1'b0;
    vdd_level = 8'hc0;
    vbat_level = 8'h80;
    cyc(20);
    `CHK(reg_oe, 1'b0)
    `CHK(osc_out, 1'b0)
    nrst = 1'b1;
    cyc(9);
    `CHK(por_n, 1'b0)
    cyc(1);
    `CHK(por_n, 1'b1)
    exp_cnt = 32'h1234;
    wr_do(HPC_SEL_LOAD, 32'h1234);
    `CHK(cnt, exp_cnt[31:0])
    ctrl = 8'h08; // pin wake only
    slp();
    `CHK(reg_oe, 1'b1)
    `CHK(reg_o, 1'b0)
    `CHK(por_n, 1'b0)
    cyc(6);
    `CHK(regulator_off_n, 1'b1)
    wake_req = 1'b1;
    cyc(2);
    `CHK(reg_oe, 1'b0)
    wake_req = 1'b0;
    for (i = 0; i < 10 && vdd_good !== 1'b1; i++) cyc(1);
    for (i = 0; i < 20 && por_n !== 1'b1; i++) cyc(1);
    `CHK(i >= 10 && i <= 13, 1'b1)
    ctrl = 8'h00;
    slp();
    cyc(3);
    `CHK(reg_oe, 1'b0)
    ctrl = 8'h04; // counter match wake only
    exp_cnt = 5;
    wr_do(HPC_SEL_LOAD, 32'h5);
    `CHK(cnt, exp_cnt[31:0])
    wr_do(HPC_SEL_MATCH1, 32'h6);
    slp();
    cyc(8);
    `CHK(reg_oe, 1'b1)
    wr_do(HPC_SEL_LOAD, 32'h6);
    for (i = 0; i < 6 && reg_oe !== 1'b0; i++) cyc(1);
    `CHK(reg_oe, 1'b0)
    cyc(25);
    // match register 0, after moving the counter off the match 1 value
    wr_do(HPC_SEL_MATCH0, 32'h9);
    wr_do(HPC_SEL_LOAD, 32'h8);
    slp();
    cyc(3);
    `CHK(reg_oe, 1'b1)
    wr_do(HPC_SEL_LOAD, 32'h9);
    for (i = 0; i < 6 && reg_oe !== 1'b0; i++) cyc(1);
    `CHK(reg_oe, 1'b0)
    cyc(25);
    vbat_level = 8'h5f;
    ctrl = 8'h0b; // pin wake, detect and abort
    slp();
    cyc(3);
    `CHK(low_batt, 1'b1)
    `CHK(reg_oe, 1'b0)
    ctrl = 8'h02;
    for (int k = 0; k < 40; k++) begin
      vdd_level = 8'($random(seed));
      vbat_level = 8'($random(seed));
      cyc(2);
      `CHK(from_batt, vbat_level > vdd_level)
      `CHK(low_batt, vbat_level < `HPC_LOWBAT_LEVEL)
    end
    ctrl = 8'h80; // crystal path
    cyc(20);
    a = osc_out;
    cyc(3);
    `CHK(osc_out, ~a)
    wr_do(HPC_SEL_LOAD, 32'h1);
    wr_do(HPC_SEL_LOAD, 32'h2);
    `CHK(dur > 128 * 6 - 12 && dur <= 128 * 6, 1'b1)
    wr.valid = 1'b1;
    wr.sel = HPC_SEL_LOAD;
    wr.data = 32'haa;
    cyc(1);
    wr.valid = 1'b0;
    cyc(3);
    wr.valid = 1'b1;
    wr.data = 32'hbb;
    cyc(1);
    wr.valid = 1'b0;
    for (i = 0; i < 900 && wr_busy !== 1'b0; i++) cyc(1);
    cyc(1);
    `CHK(cnt, 32'haa)
    ctrl = 8'he0; // straight-through oscillator, counter enabled
    osc_slow = 1'b1;
    cyc(2);
    `CHK(osc_out, 1'b0)
    wr_do(HPC_SEL_LOAD, 32'h3);
    wr_do(HPC_SEL_LOAD, 32'h4);
    `CHK(dur > 18 && dur <= 30, 1'b1)
    `CHK(cnt, 32'h4)
    cyc(1);
    `CHK(cnt, 32'h4)
    summarize();
  end
endmodule : hpc_top_test
